// ==== test/bdt_core_debug_properties.sv ====
// Purpose: port-level checks of the debug block
// Assumes: bench keeps ce high
// Notes:   trace checks rely on the two-cycle trace clock
`default_nettype none
module bdt_core_debug_properties #(
  parameter int ADDR_W = 32
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire bdt_pkg::bdt_nib_t cpu_ddata,
  input wire logic              halt_req,
  input wire logic              debug_irq,
  input wire logic              irq_allow,
  input wire bdt_pkg::bdt_nib_t processor_status_bus,
  input wire bdt_pkg::bdt_nib_t debug_data_bus,
  input wire logic              status_trace_clock,
  input wire logic              all_status_high
);
  import bdt_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_status_and: assert property (
    all_status_high == &processor_status_bus)
    else $error("all-status output is not the AND of the status bus");
  a_halt_shows: assert property (
    $rose(halt_req) |-> ##[1:3] processor_status_bus == 4'hF)
    else $error("halt not shown on the status bus");
  // the status bus may lag a resume by one trace period
  a_ones_mean_halt: assert property (
    processor_status_bus == 4'hF |-> $past(halt_req) || $past(halt_req, 2) || $past(halt_req, 3))
    else $error("all-ones status without a halt");
  a_trace_toggle: assert property (
    !$past(rst) && $past(ce) |-> status_trace_clock != $past(status_trace_clock))
    else $error("trace clock missed a toggle");
  a_step_on_fall: assert property (
    $changed({processor_status_bus, debug_data_bus}) |-> $fell(status_trace_clock))
    else $error("trace outputs changed off the trace clock fall");
  a_ddata_follow: assert property (
    $fell(status_trace_clock) |-> debug_data_bus == $past(cpu_ddata))
    else $error("debug data bus does not carry core data");
  a_one_action: assert property (
    !(halt_req && debug_irq))
    else $error("halt and debug interrupt both active");
  a_irq_allow: assert property (
    !debug_irq && !$past(debug_irq) |-> irq_allow)
    else $error("interrupts blocked outside debug interrupt mode");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= ADDR_W'(32'h0000_002C)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule

bind bdt_core_debug bdt_core_debug_properties #(.ADDR_W(ADDR_W)) chk (
  .clk, .rst, .ce, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .cpu_ddata, .halt_req, .debug_irq, .irq_allow,
  .processor_status_bus, .debug_data_bus, .status_trace_clock, .all_status_high
);
`default_nettype wire

// ==== test/bdt_core_debug_test.sv ====
// Purpose: self-checking bench of the debug block
// Assumes: ce held high, full write strobes except one merge case
// Notes:   random values from a bench lfsr seeded with 42
`default_nettype none
module bdt_core_debug_test;
  timeunit 1ns;
  timeprecision 1ps;
  import bdt_pkg::*;
  logic        clk, rst, ce, cpu_valid, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, halt_req, debug_irq, irq_allow;
  logic        serial_debug_clock, serial_debug_in, serial_debug_out;
  logic        status_trace_clock, all_status_high;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed, tseed, a, m;
  logic [31:0] bp [9];
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  cpu_irq_level;
  bdt_word_t   cpu_addr, cpu_data, cpu_pc;
  bdt_nib_t    cpu_status, cpu_ddata, processor_status_bus, debug_data_bus;
  int          num_errors, n_tests;

  bdt_core_debug uut (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_debug_clock, .serial_debug_in,
    .serial_debug_out, .cpu_addr, .cpu_data, .cpu_pc, .cpu_valid, .cpu_status, .cpu_ddata,
    .cpu_irq_level, .halt_req, .debug_irq, .irq_allow, .processor_status_bus,
    .debug_data_bus, .status_trace_clock, .all_status_high);
  bdt_tool_model tool (.serial_debug_out, .serial_debug_clock, .serial_debug_in);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [31:0] ad, input logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdc(input logic [31:0] ad, input logic [31:0] exp);
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    s_axi_rready <= 1'b0;
  endtask
  task automatic test_done;
    if (num_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // trace inputs wander every cycle, all-ones included
  always @(posedge clk) begin
    tseed <= lfsr(tseed);
    {cpu_status, cpu_ddata} <= tseed[7:0];
  end
  initial begin
    #300_000;
    num_errors++;
    test_done();
  end

  initial begin
    {rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h60;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {cpu_addr, cpu_data, cpu_pc, cpu_valid, cpu_irq_level} = '0;
    s_axi_wstrb = 4'hF;
    seed = 32'h0000_002A;
    tseed = 32'h0000_002A;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i <= 10; i++) rdc(32'(4 * i), 32'h0000_0000);
    chk({31'h0, irq_allow}, 32'h0000_0001);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      bp[i] = seed;
      wr(32'(4 * i), seed, r);
      chk({30'h0, r}, 32'h0000_0000);
    end
    for (int i = 0; i < 9; i++) rdc(32'(4 * i), bp[i]);
    wr(32'h0000_002C, seed, r);
    chk({30'h0, r}, 32'h0000_0002);
    rdc(32'h0000_002C, 32'h0000_0000);
    seed = lfsr(seed);
    tool.frame({1'b1, 4'h0, seed});
    rdc(32'h0000_0000, seed);
    tool.frame({1'b0, 4'h2, 32'h0000_0000});
    chk(tool.reply, bp[0]);
    tool.frame({1'b0, 4'hB, 32'h0000_0000});
    chk(tool.reply, bp[2]);
    // single level on a masked address, halting
    a = lfsr(seed);
    m = lfsr(a);
    wr(32'h0000_0000, a, r);
    wr(32'h0000_0004, m, r);
    wr(32'h0000_0024, 32'h0000_0001, r);
    cpu_addr <= a ^ (lfsr(m) & m);
    cpu_valid <= 1'b1;
    @(posedge clk);
    cpu_valid <= 1'b0;
    for (int k = 0; k < 12 && processor_status_bus !== 4'hF; k++) @(posedge clk);
    chk({30'h0, debug_irq, halt_req}, 32'h0000_0001);
    chk({27'h0, all_status_high, processor_status_bus}, 32'h0000_001F);
    rdc(32'h0000_0028, 32'h0000_0005);
    wr(32'h0000_0024, 32'h0000_0100, r);
    chk({30'h0, debug_irq, halt_req}, 32'h0000_0000);
    // low two byte lanes only: the upper half keeps its old value
    s_axi_wstrb <= 4'h3;
    wr(32'h0000_0000, 32'hFFFF_FFFF, r);
    s_axi_wstrb <= 4'hF;
    rdc(32'h0000_0000, {a[31:16], 16'hFFFF});
    // dual level: data match arms, pc match fires a debug interrupt
    wr(32'h0000_0008, a, r);
    wr(32'h0000_000C, 32'h0000_0000, r);
    wr(32'h0000_0014, m, r);
    wr(32'h0000_0020, 32'h0000_0000, r);
    wr(32'h0000_0024, 32'h0000_0AE2, r);
    cpu_data <= a;
    cpu_pc <= ~m;
    cpu_valid <= 1'b1;
    @(posedge clk);
    cpu_valid <= 1'b0;
    rdc(32'h0000_0028, 32'h0000_0006);
    chk({30'h0, debug_irq, halt_req}, 32'h0000_0000);
    cpu_data <= ~a;
    cpu_pc <= m;
    cpu_valid <= 1'b1;
    @(posedge clk);
    cpu_valid <= 1'b0;
    for (int k = 0; k < 12 && debug_irq !== 1'b1; k++) @(posedge clk);
    chk({30'h0, debug_irq, halt_req}, 32'h0000_0002);
    cpu_irq_level <= 3'h4;
    repeat (3) @(posedge clk);
    chk({31'h0, irq_allow}, 32'h0000_0000);
    cpu_irq_level <= 3'h5;
    repeat (3) @(posedge clk);
    chk({31'h0, irq_allow}, 32'h0000_0001);
    wr(32'h0000_0024, 32'h0000_0100, r);
    chk({30'h0, debug_irq, halt_req}, 32'h0000_0000);
    // sticky trigger flag survives a resume and clears on a write of one
    rdc(32'h0000_0028, 32'h0000_0004);
    wr(32'h0000_0028, 32'h0000_0004, r);
    rdc(32'h0000_0028, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire

// ==== test/bdt_tool_model.sv ====
// Purpose: debug tool on the serial channel
// Assumes: serial clock idles low, 80 ns period
// Notes:   the reply of a frame is collected during the next frame
`default_nettype none
module bdt_tool_model (
  input  wire logic serial_debug_out,
  output logic      serial_debug_clock,
  output logic      serial_debug_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] reply;
  initial begin
    serial_debug_clock = 1'b0;
    serial_debug_in = 1'b1;
  end
  // shift a frame msb first and sample the reply on the first 32 rises
  task automatic frame(input logic [36:0] word);
    // step off the system clock edge so the pins never race the sampling flops
    #1;
    for (int i = 36; i >= 0; i--) begin
      serial_debug_in = word[i];
      #40 serial_debug_clock = 1'b1;
      if (i >= 5) reply[i-5] = serial_debug_out;
      #40 serial_debug_clock = 1'b0;
    end
    // released line must not look held
    serial_debug_in = ~serial_debug_in;
    #40;
  endtask
endmodule
`default_nettype wire

// ==== verilog/bdt_core_debug.sv ====
// Purpose: breakpoint registers, trigger logic, halt/debug-interrupt and real-time trace
// Assumes: core-side inputs are on clk; serial pins are asynchronous
// Notes:   serial frame is 37 bits msb first: write flag, 4-bit index, 32-bit data
//
// Function
// - Nine 32-bit breakpoint registers: address and mask, data and mask, four pc and pc mask.
// - Both the serial debug channel and the processor bus can read and write them.
// - Triggers combine address, data and pc matches as single- or dual-level definitions.
// - A trigger either halts the processor or starts a debug interrupt, as programmed.
// - In emulator mode, critical interrupts at or above a set level are still serviced.
// - A 4-bit status bus and 4-bit data bus are driven with a trace clock at half the cpu rate.
// - The all-status output is the AND of the four status bits.
// - The halted state shows as all four status bits high.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`include "bdt_regs.svh"
`default_nettype none
module bdt_core_debug #(
  parameter int ADDR_W = 32
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_debug_clock,
  input  wire logic              serial_debug_in,
  output logic                   serial_debug_out,
  input  wire bdt_pkg::bdt_word_t cpu_addr,
  input  wire bdt_pkg::bdt_word_t cpu_data,
  input  wire bdt_pkg::bdt_word_t cpu_pc,
  input  wire logic              cpu_valid,
  input  wire bdt_pkg::bdt_nib_t cpu_status,
  input  wire bdt_pkg::bdt_nib_t cpu_ddata,
  input  wire logic [2:0]        cpu_irq_level,
  output logic                   halt_req,
  output logic                   debug_irq,
  output logic                   irq_allow,
  output bdt_pkg::bdt_nib_t      processor_status_bus,
  output bdt_pkg::bdt_nib_t      debug_data_bus,
  output logic                   status_trace_clock,
  output logic                   all_status_high
);
  import bdt_pkg::*;

  initial begin
    if (ADDR_W < 6 || ADDR_W > 32) begin
      $error("bdt_core_debug: ADDR_W must lie in 6..32");
    end
  end

  function automatic logic idx_ok(input logic [3:0] idx);
    idx_ok = (idx <= `BDT_IDX_STAT);
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = ((a >> 6) == '0) && idx_ok(a[5:2]);
  endfunction

  function automatic logic cond(input logic [2:0] en, input logic ah, input logic dh,
                                input logic ph);
    cond = (en != 3'h0) && (!en[0] || ah) && (!en[1] || dh) && (!en[2] || ph);
  endfunction

  bdt_word_t bp [0:`BDT_NUM_BP-1];
  bdt_word_t ctrl;
  bdt_trig_t trig;
  logic      halted;
  logic      irq_active;
  logic      trig_seen;

  wire [3:0] stat_bits = {irq_active, trig_seen, (trig == TRG_ARMED), halted};
  wire bdt_word_t stat_word = {28'h000_0000, stat_bits};

  function automatic bdt_word_t rd_word(input logic [3:0] idx);
    if (idx < `BDT_IDX_CTRL) begin
      rd_word = bp[idx];
    end else if (idx == `BDT_IDX_CTRL) begin
      rd_word = ctrl;
    end else if (idx == `BDT_IDX_STAT) begin
      rd_word = stat_word;
    end else begin
      rd_word = 32'h0000_0000;
    end
  endfunction

  // serial channel: pins pass two flops, edges are found on the second and third
  logic sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2;
  logic [36:0] ser_shift;
  logic [5:0]  ser_cnt;
  logic        ser_exec;
  logic [36:0] ser_cmd;
  logic [31:0] ser_out;

  wire sclk_rise = sclk_s2 & ~sclk_s3;
  wire sclk_fall = ~sclk_s2 & sclk_s3;
  wire ser_last  = sclk_rise && (ser_cnt == `BDT_SER_BITS - 6'h1);
  wire ser_wr    = ser_exec && ser_cmd[36] && idx_ok(ser_cmd[35:32]);

  always_ff @(posedge clk) begin
    if (rst) begin
      {sclk_s1, sclk_s2, sclk_s3, sdi_s1, sdi_s2} <= 5'h00;
      ser_shift <= '0;
      ser_cnt   <= 6'h00;
      ser_exec  <= 1'b0;
      ser_cmd   <= '0;
    end else if (ce) begin
      {sclk_s1, sclk_s2, sclk_s3} <= {serial_debug_clock, sclk_s1, sclk_s2};
      {sdi_s1, sdi_s2} <= {serial_debug_in, sdi_s1};
      ser_exec <= ser_last;
      if (sclk_rise) begin
        ser_shift <= {ser_shift[35:0], sdi_s2};
        ser_cnt   <= ser_last ? 6'h00 : ser_cnt + 6'h01;
      end
      if (ser_last) begin
        ser_cmd <= {ser_shift[35:0], sdi_s2};
      end
    end
  end

  // reply word is loaded after the frame and clocked out on falling serial edges
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_out          <= 32'h0000_0000;
      serial_debug_out <= 1'b0;
    end else if (ce) begin
      if (ser_exec) begin
        ser_out <= rd_word(ser_cmd[35:32]);
      end else if (sclk_fall) begin
        ser_out          <= {ser_out[30:0], 1'b0};
        serial_debug_out <= ser_out[31];
      end
    end
  end

  // axi4-lite write: address and data taken in either order, serial writes go first
  logic              aw_held, w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  wire       aw_take   = s_axi_awvalid & s_axi_awready;
  wire       w_take    = s_axi_wvalid & s_axi_wready;
  wire       axi_do_wr = aw_held & w_held & ~s_axi_bvalid & ~ser_wr;
  wire       axi_ok    = addr_ok(aw_addr_q);
  wire [3:0] axi_idx   = aw_addr_q[5:2];
  wire bdt_word_t axi_old = rd_word(axi_idx);
  wire bdt_word_t axi_merged;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign axi_merged[8*gb +: 8] = w_strb_q[gb] ? w_data_q[8*gb +: 8] : axi_old[8*gb +: 8];
    end
  endgenerate

  wire            wr_en   = ser_wr | (axi_do_wr & axi_ok);
  wire [3:0]      wr_idx  = ser_wr ? ser_cmd[35:32] : axi_idx;
  wire bdt_word_t wr_data = ser_wr ? ser_cmd[31:0] : axi_merged;
  wire            wr_ctrl = wr_en && (wr_idx == `BDT_IDX_CTRL);
  wire            wr_stat = wr_en && (wr_idx == `BDT_IDX_STAT);
  wire            go      = wr_ctrl && wr_data[`BDT_CTRL_GO];

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `BDT_RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= ~(aw_held | aw_take) | axi_do_wr;
      s_axi_wready  <= ~(w_held | w_take) | axi_do_wr;
      if (aw_take) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (axi_do_wr) begin
        aw_held <= 1'b0;
      end
      if (w_take) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (axi_do_wr) begin
        w_held <= 1'b0;
      end
      if (axi_do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= axi_ok ? `BDT_RESP_OKAY : `BDT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  wire ar_take = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `BDT_RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= addr_ok(s_axi_araddr) ? rd_word(s_axi_araddr[5:2]) : 32'h0000_0000;
        s_axi_rresp   <= addr_ok(s_axi_araddr) ? `BDT_RESP_OKAY : `BDT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // breakpoint register file
  genvar gi;
  generate
    for (gi = 0; gi < `BDT_NUM_BP; gi++) begin : g_bp
      always_ff @(posedge clk) begin
        if (rst) begin
          bp[gi] <= `BDT_BP_RESET;
        end else if (ce && wr_en && (wr_idx == 4'(gi))) begin
          bp[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `BDT_CTRL_RESET;
    end else if (ce && wr_ctrl) begin
      ctrl <= wr_data & `BDT_CTRL_WMASK & ~(32'h0000_0001 << `BDT_CTRL_GO);
    end
  end

  // match units: address, data, and four pc comparands sharing one mask
  logic a_hit, d_hit;
  logic [3:0] pc_hits;

  bdt_match #(.W(32)) u_addr (.value(cpu_addr), .comparand(bp[`BDT_IDX_ADDR]),
                              .mask(bp[`BDT_IDX_ADDR_MASK]), .hit(a_hit));
  bdt_match #(.W(32)) u_data (.value(cpu_data), .comparand(bp[`BDT_IDX_DATA]),
                              .mask(bp[`BDT_IDX_DATA_MASK]), .hit(d_hit));
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pc
      bdt_match #(.W(32)) u_pc (.value(cpu_pc), .comparand(bp[`BDT_IDX_PC0 + gi]),
                                .mask(bp[`BDT_IDX_PC_MASK]), .hit(pc_hits[gi]));
    end
  endgenerate

  wire       p_hit  = |pc_hits;
  wire [2:0] en1    = ctrl[`BDT_CTRL_EN1_LSB +: 3];
  wire [2:0] en2    = ctrl[`BDT_CTRL_EN2_LSB +: 3];
  wire       dual   = ctrl[`BDT_CTRL_DUAL];
  wire       act_irq = ctrl[`BDT_CTRL_ACT_IRQ];
  wire       l1_hit = cpu_valid && cond(en1, a_hit, d_hit, p_hit);
  wire       l2_hit = cpu_valid && cond(en2, a_hit, d_hit, p_hit);
  wire       fire   = dual ? (trig == TRG_ARMED) && l2_hit : (trig == TRG_IDLE) && l1_hit;
  bdt_trig_t next_trig;

  always_comb begin
    next_trig = trig;
    unique case (trig)
      TRG_IDLE:  if (dual && l1_hit) begin
        next_trig = TRG_ARMED;
      end else if (fire) begin
        next_trig = TRG_FIRED;
      end
      TRG_ARMED: if (fire) begin
        next_trig = TRG_FIRED;
      end else if (!dual) begin
        next_trig = TRG_IDLE;
      end
      TRG_FIRED: if (go) begin
        next_trig = TRG_IDLE;
      end
      default: next_trig = TRG_IDLE;
    endcase
  end

  // a new event wins over a resume or a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      trig       <= TRG_IDLE;
      halted     <= 1'b0;
      irq_active <= 1'b0;
      trig_seen  <= 1'b0;
      halt_req   <= 1'b0;
      debug_irq  <= 1'b0;
      irq_allow  <= 1'b1;
    end else if (ce) begin
      trig       <= next_trig;
      halted     <= (fire && !act_irq) || (halted && !go);
      irq_active <= (fire && act_irq) || (irq_active && !go);
      trig_seen  <= fire || (trig_seen && !(wr_stat && wr_data[`BDT_STAT_TRIG]));
      halt_req   <= (fire && !act_irq) || (halted && !go);
      debug_irq  <= (fire && act_irq) || (irq_active && !go);
      // only interrupts at or above the critical level get through in emulator mode
      irq_allow  <= !irq_active || (cpu_irq_level >= ctrl[`BDT_CTRL_LVL_LSB +: 3]);
    end
  end

  // trace: outputs change as the trace clock falls, so the tool samples on its rise
  wire bdt_nib_t run_status = (cpu_status == `BDT_PST_HALT) ? `BDT_PST_RUN_CLAMP : cpu_status;
  wire bdt_nib_t next_pst   = halted ? `BDT_PST_HALT : run_status;

  always_ff @(posedge clk) begin
    if (rst) begin
      status_trace_clock   <= 1'b0;
      processor_status_bus <= 4'h0;
      debug_data_bus       <= 4'h0;
      all_status_high      <= 1'b0;
    end else if (ce) begin
      status_trace_clock <= ~status_trace_clock;
      if (status_trace_clock) begin
        processor_status_bus <= next_pst;
        debug_data_bus       <= cpu_ddata;
        all_status_high      <= &next_pst;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/bdt_match.sv ====
// Purpose: masked equality compare of one value against a comparand
// Assumes: a mask bit of one excludes that bit from the compare
// Notes:   combinational
`default_nettype none
module bdt_match #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] comparand,
  input  wire logic [W-1:0] mask,
  output logic              hit
);
  assign hit = (((value ^ comparand) & ~mask) == '0);
endmodule
`default_nettype wire

// ==== verilog/bdt_pkg.sv ====
// Purpose: types shared by the debug block
// Assumes: nothing
// Notes:   offsets and fields live in bdt_regs.svh
`default_nettype none
package bdt_pkg;
  typedef logic [31:0] bdt_word_t;
  typedef logic [3:0]  bdt_nib_t;
  typedef enum logic [1:0] {TRG_IDLE, TRG_ARMED, TRG_FIRED} bdt_trig_t;
endpackage
`default_nettype wire

// ==== verilog/bdt_regs.svh ====
// Purpose: register indices, field positions and reset values of the debug block
// Assumes: byte address of a register is four times its index
// Notes:   definitions only
`ifndef BDT_REGS_SVH
`define BDT_REGS_SVH

`define BDT_IDX_ADDR      4'h0
`define BDT_IDX_ADDR_MASK 4'h1
`define BDT_IDX_DATA      4'h2
`define BDT_IDX_DATA_MASK 4'h3
`define BDT_IDX_PC0       4'h4
`define BDT_IDX_PC_MASK   4'h8
`define BDT_IDX_CTRL      4'h9
`define BDT_IDX_STAT      4'hA
`define BDT_NUM_BP        9

`define BDT_CTRL_EN1_LSB  0
`define BDT_CTRL_EN2_LSB  3
`define BDT_CTRL_DUAL     6
`define BDT_CTRL_ACT_IRQ  7
`define BDT_CTRL_GO       8
`define BDT_CTRL_LVL_LSB  9
`define BDT_CTRL_WMASK    32'h0000_0EFF

`define BDT_STAT_HALTED   0
`define BDT_STAT_ARMED    1
`define BDT_STAT_TRIG     2
`define BDT_STAT_IRQ      3

`define BDT_BP_RESET      32'h0000_0000
`define BDT_CTRL_RESET    32'h0000_0000
`define BDT_PST_HALT      4'hF
`define BDT_PST_RUN_CLAMP 4'hE
`define BDT_SER_BITS      6'h25
`define BDT_RESP_OKAY     2'h0
`define BDT_RESP_SLVERR   2'h2

`endif
